/* rtl/osc_trim_ctrl.sv */
// Functional notes
// - after crystal enable, wait trim-delay steps then load stored trim; zero loads at once
// - after trim applied, wait settle-delay steps then flag settled; zero flags at once
// - nonzero code n waits between n-1 and n steps of 250 us
// - low-power select picks RC at 0, RCX at 1; resets to 0
// - slow RC enable in bit 7, resets set
// - slow crystal enable in bit 0, resets cleared
// - fast RC enable in bit 0, resets cleared
// - RCX enable in bit 11, resets cleared, independent of select
// - slow RC trim 4 bits, low to high frequency, default 0x7
// - fast RC trim 4 bits, low to high frequency, resets zero
// - RCX trim 4 bits in low nibble
// - fast crystal bias current 3 bits, resets 0x5
// - slow crystal bias current 4 bits, resets 0x5
// - slow crystal bias resistor 2 bits, max at 0, resets 0x3
// - status shows boost mode bit 9 and reference good bit 7, read-only
// - status shows battery, regulator, converter and low rail flags, read-only
// - fast crystal noise filter enable in bit 9, resets cleared
// - reference register holds 5-bit bias and voltage trims, reset zero
// - settled flag is read-only bit 7 of system status, resets 0
// - trim-ready bit 6 shows applied trim equals stored, resets 1
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module osc_trim_ctrl import osc_trim_pkg::*; #(
  parameter int STEP_LEN = STEP_CYCLES
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [31:0] addr, // register address
  input wire logic [15:0] wdata, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [15:0] rdata, // read data, cycle after rd_en
  input wire logic [9:0] ana_status_in, // raw analogue flags
  output logic fast_crystal_enable, // fast crystal on
  output logic [15:0] applied_trim, // trim driven to crystal
  output logic fast_crystal_settled, // crystal settled
  output logic fast_crystal_trim_ready, // applied equals stored
  output logic slow_rc_enable, // slow rc on
  output logic [3:0] slow_rc_trim, // slow rc trim
  output logic slow_crystal_enable, // slow crystal on
  output logic slow_crystal_ampreg_off, // amplitude regulation off
  output logic [3:0] slow_crystal_bias_current, // slow crystal bias
  output logic [1:0] slow_crystal_bias_resistor, // slow crystal resistor
  output logic fast_rc_enable, // fast rc on
  output logic [3:0] fast_rc_trim, // fast rc trim
  output logic fast_crystal_noise_filter, // noise filter on
  output logic fast_crystal_bias_hold, // bias sample/hold on
  output logic [2:0] fast_crystal_bias_current, // fast crystal bias
  output logic low_power_osc_select, // 0 slow rc, 1 rcx
  output logic low_power_osc_enable, // rcx on
  output logic [3:0] low_power_osc_trim, // rcx trim
  output logic [6:0] low_power_osc_tune, // rcx low-f, bias, temp
  output logic reference_core_off_test, // reference core off
  output logic [4:0] reference_bias_trim, // reference bias trim
  output logic [4:0] reference_voltage_trim, // reference voltage trim
  output logic [3:0] retention_trim // retention regulator trim
);
  logic [15:0] trim_timing_r;
  logic [15:0] slow_osc_r;
  logic [15:0] fast_osc_r;
  logic [15:0] lp_osc_r;
  logic [15:0] ref_trim_r;
  logic [15:0] freq_trim_r;
  logic [15:0] xtal_ctrl_r;
  logic [15:0] applied_r;
  logic [15:0] rdata_r;
  logic [9:0] ana_meta_r;
  logic [9:0] ana_s2_r;
  logic [9:0] ana_s3_r;
  logic [9:0] ana_stat_r;
  logic [3:0] cnt_r;
  logic settled_r;
  logic ready_r;
  logic xtal_en;
  logic step_tick;
  logic apply;
  xtal_state_e state_r;

  // address match for a register
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  // masked register update
  function automatic logic [15:0] upd(input logic [15:0] old, input logic [15:0] d,
                                      input logic [15:0] m);
    upd = (old & ~m) | (d & m);
  endfunction

  step_timebase #(.STEP_LEN(STEP_LEN)) u_step (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(step_tick)
  );

  // software writes to the control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_timing_r <= TRIM_TIMING_RST;
      slow_osc_r <= SLOW_OSC_RST;
      fast_osc_r <= FAST_OSC_RST;
      lp_osc_r <= LP_OSC_RST;
      ref_trim_r <= REF_TRIM_RST;
      freq_trim_r <= FREQ_TRIM_RST;
      xtal_ctrl_r <= XTAL_CTRL_RST;
    end else if (wr_en) begin
      if (hit(addr, ADDR_TRIM_TIMING)) begin
        trim_timing_r <= upd(trim_timing_r, wdata, TRIM_TIMING_MASK);
      end
      if (hit(addr, ADDR_SLOW_OSC)) begin
        slow_osc_r <= upd(slow_osc_r, wdata, SLOW_OSC_MASK);
      end
      if (hit(addr, ADDR_FAST_OSC)) begin
        fast_osc_r <= upd(fast_osc_r, wdata, FAST_OSC_MASK);
      end
      if (hit(addr, ADDR_LP_OSC)) begin
        lp_osc_r <= upd(lp_osc_r, wdata, LP_OSC_MASK);
      end
      if (hit(addr, ADDR_REF_TRIM)) begin
        ref_trim_r <= upd(ref_trim_r, wdata, REF_TRIM_MASK);
      end
      if (hit(addr, ADDR_FREQ_TRIM)) begin
        freq_trim_r <= wdata;
      end
      if (hit(addr, ADDR_XTAL_CTRL)) begin
        xtal_ctrl_r <= upd(xtal_ctrl_r, wdata, XTAL_CTRL_MASK);
      end
    end
  end

  // analogue flags: three stages, accept once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ana_meta_r <= ANA_STATUS_RST;
      ana_s2_r <= ANA_STATUS_RST;
      ana_s3_r <= ANA_STATUS_RST;
      ana_stat_r <= ANA_STATUS_RST;
    end else begin
      ana_meta_r <= ana_status_in;
      ana_s2_r <= ana_meta_r;
      ana_s3_r <= ana_s2_r;
      for (int i = 0; i < 10; i++) begin
        if (ana_s2_r[i] == ana_s3_r[i]) begin
          ana_stat_r[i] <= ana_s3_r[i];
        end
      end
    end
  end

  assign xtal_en = xtal_ctrl_r[XTAL_EN_BIT];
  // load the stored trim when the trim wait has run out
  assign apply = (state_r == ST_TRIM) && xtal_en && (cnt_r == 4'h0);

  // trim-then-settle sequencer, counting step ticks, the first of which may come at any phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (xtal_en) begin
            state_r <= ST_TRIM;
            cnt_r <= trim_timing_r[TRIM_TIME_LSB +: 4];
          end
        end
        ST_TRIM: begin
          if (!xtal_en) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
          end else if (cnt_r == 4'h0) begin
            state_r <= ST_SETTLE;
            cnt_r <= trim_timing_r[SETTLE_TIME_LSB +: 4];
          end else if (step_tick) begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ST_SETTLE: begin
          if (!xtal_en) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
          end else if (cnt_r == 4'h0) begin
            state_r <= ST_DONE;
          end else if (step_tick) begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ST_DONE: begin
          if (!xtal_en) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          cnt_r <= 4'h0;
        end
      endcase
    end
  end

  // applied trim and settled flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      applied_r <= FREQ_TRIM_RST;
      settled_r <= 1'b0;
    end else begin
      if (apply) begin
        applied_r <= freq_trim_r;
      end
      if (!xtal_en) begin
        settled_r <= 1'b0;
      end else if (state_r == ST_SETTLE && cnt_r == 4'h0) begin
        settled_r <= 1'b1;
      end
    end
  end

  // trim-ready compares applied with stored trim
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_r <= 1'b1;
    end else begin
      ready_r <= (applied_r == freq_trim_r);
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else if (rd_en) begin
      case (1'b1)
        hit(addr, ADDR_SYS_STATUS): begin
          rdata_r <= 16'h0000;
          rdata_r[STAT_SETTLED_BIT] <= settled_r;
          rdata_r[STAT_READY_BIT] <= ready_r;
        end
        hit(addr, ADDR_TRIM_TIMING): rdata_r <= trim_timing_r;
        hit(addr, ADDR_SLOW_OSC): rdata_r <= slow_osc_r;
        hit(addr, ADDR_FAST_OSC): rdata_r <= fast_osc_r;
        hit(addr, ADDR_LP_OSC): rdata_r <= lp_osc_r;
        hit(addr, ADDR_REF_TRIM): rdata_r <= ref_trim_r;
        hit(addr, ADDR_ANA_STATUS): rdata_r <= {6'h00, ana_stat_r & ANA_STATUS_MASK};
        hit(addr, ADDR_FREQ_TRIM): rdata_r <= freq_trim_r;
        hit(addr, ADDR_XTAL_CTRL): rdata_r <= xtal_ctrl_r;
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign rdata = rdata_r;
  assign fast_crystal_enable = xtal_en;
  assign applied_trim = applied_r;
  assign fast_crystal_settled = settled_r;
  assign fast_crystal_trim_ready = ready_r;

  // slow oscillator fields
  assign slow_crystal_ampreg_off = slow_osc_r[SLOW_AMPREG_BIT];
  assign slow_rc_trim = slow_osc_r[SLOW_RC_TRIM_LSB +: 4];
  assign slow_rc_enable = slow_osc_r[SLOW_RC_EN_BIT];
  assign slow_crystal_bias_current = slow_osc_r[SLOW_CUR_LSB +: 4];
  assign slow_crystal_bias_resistor = slow_osc_r[SLOW_RBIAS_LSB +: 2];
  assign slow_crystal_enable = slow_osc_r[SLOW_XTAL_EN_BIT];

  // fast oscillator fields
  assign fast_crystal_noise_filter = fast_osc_r[FAST_FILT_BIT];
  assign fast_crystal_bias_hold = fast_osc_r[FAST_HOLD_BIT];
  assign fast_crystal_bias_current = fast_osc_r[FAST_CUR_LSB +: 3];
  assign fast_rc_trim = fast_osc_r[FAST_RC_TRIM_LSB +: 4];
  assign fast_rc_enable = fast_osc_r[FAST_RC_EN_BIT];

  // low-power oscillator fields; enable does not depend on select
  assign low_power_osc_select = lp_osc_r[LP_SEL_BIT];
  assign low_power_osc_enable = lp_osc_r[LP_EN_BIT];
  assign low_power_osc_tune = lp_osc_r[LP_TUNE_LSB +: 7];
  assign low_power_osc_trim = lp_osc_r[LP_TRIM_LSB +: 4];

  // reference fields
  assign reference_core_off_test = ref_trim_r[REF_TEST_BIT];
  assign retention_trim = ref_trim_r[REF_RET_LSB +: 4];
  assign reference_bias_trim = ref_trim_r[REF_BIAS_LSB +: 5];
  assign reference_voltage_trim = ref_trim_r[REF_VOLT_LSB +: 5];

  // checks on the sequencer and register paths
  property p_trim_load;
    @(posedge sys_clk) disable iff (!rst_n)
    apply |=> state_r == ST_SETTLE && applied_r == $past(freq_trim_r);
  endproperty
  a_trim_load: assert property (p_trim_load) else $error("trim not loaded");

  property p_settle_flag;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_r == ST_SETTLE && cnt_r == 4'h0 && xtal_en) |=> settled_r;
  endproperty
  a_settle_flag: assert property (p_settle_flag) else $error("settled late");

  property p_step_count;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_r == ST_TRIM && xtal_en && cnt_r != 4'h0 && step_tick)
      |=> cnt_r == $past(cnt_r) - 4'h1;
  endproperty
  a_step_count: assert property (p_step_count) else $error("step missed");

  property p_step_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_r == ST_SETTLE && xtal_en && cnt_r != 4'h0 && !step_tick)
      |=> state_r == ST_SETTLE && $stable(cnt_r);
  endproperty
  a_step_hold: assert property (p_step_hold) else $error("count moved");

  property p_disable;
    @(posedge sys_clk) disable iff (!rst_n)
    !xtal_en |=> !settled_r && state_r == ST_IDLE;
  endproperty
  a_disable: assert property (p_disable) else $error("not restarted");

  property p_settled_src;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(settled_r) |-> $past(state_r) == ST_SETTLE;
  endproperty
  a_settled_src: assert property (p_settled_src) else $error("bad settled");

  property p_ready;
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> ready_r == ($past(applied_r) == $past(freq_trim_r));
  endproperty
  a_ready: assert property (p_ready) else $error("ready wrong");

  property p_select_wr;
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_en && hit(addr, ADDR_LP_OSC)) |=> low_power_osc_select == $past(wdata[LP_SEL_BIT]);
  endproperty
  a_select_wr: assert property (p_select_wr) else $error("select lost");

  property p_ana_read;
    @(posedge sys_clk) disable iff (!rst_n)
    (rd_en && hit(addr, ADDR_ANA_STATUS))
      |=> rdata == {6'h00, $past(ana_stat_r) & ANA_STATUS_MASK};
  endproperty
  a_ana_read: assert property (p_ana_read) else $error("status read");

  c_settled: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(settled_r));
  c_apply: cover property (@(posedge sys_clk) disable iff (!rst_n) apply);
  c_abort: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == ST_SETTLE && !xtal_en);
endmodule

/* shared/osc_trim_pkg.sv */
package osc_trim_pkg;
  // register addresses
  localparam logic [31:0] ADDR_SYS_STATUS = 32'h5000_0014;
  localparam logic [31:0] ADDR_TRIM_TIMING = 32'h5000_0016;
  localparam logic [31:0] ADDR_SLOW_OSC = 32'h5000_0020;
  localparam logic [31:0] ADDR_FAST_OSC = 32'h5000_0022;
  localparam logic [31:0] ADDR_LP_OSC = 32'h5000_0024;
  localparam logic [31:0] ADDR_REF_TRIM = 32'h5000_0028;
  localparam logic [31:0] ADDR_ANA_STATUS = 32'h5000_002A;
  localparam logic [31:0] ADDR_FREQ_TRIM = 32'h5000_0030;
  localparam logic [31:0] ADDR_XTAL_CTRL = 32'h5000_0032;

  // reset values and writable bit masks
  localparam logic [15:0] TRIM_TIMING_RST = 16'h00A2;
  localparam logic [15:0] TRIM_TIMING_MASK = 16'h00FF;
  localparam logic [15:0] SLOW_OSC_RST = 16'h07AE;
  localparam logic [15:0] SLOW_OSC_MASK = 16'h1FFF;
  localparam logic [15:0] FAST_OSC_RST = 16'h00A0;
  localparam logic [15:0] FAST_OSC_MASK = 16'h03FF;
  localparam logic [15:0] LP_OSC_RST = 16'h05B0;
  localparam logic [15:0] LP_OSC_MASK = 16'h1FFF;
  localparam logic [15:0] REF_TRIM_RST = 16'h0000;
  localparam logic [15:0] REF_TRIM_MASK = 16'h7FFF;
  localparam logic [15:0] FREQ_TRIM_RST = 16'h0000;
  localparam logic [15:0] XTAL_CTRL_RST = 16'h0000;
  localparam logic [15:0] XTAL_CTRL_MASK = 16'h0001;
  localparam logic [9:0] ANA_STATUS_RST = 10'h090;
  localparam logic [9:0] ANA_STATUS_MASK = 10'h2F7;

  // field positions
  localparam int TRIM_TIME_LSB = 4;
  localparam int SETTLE_TIME_LSB = 0;
  localparam int SLOW_AMPREG_BIT = 12;
  localparam int SLOW_RC_TRIM_LSB = 8;
  localparam int SLOW_RC_EN_BIT = 7;
  localparam int SLOW_CUR_LSB = 3;
  localparam int SLOW_RBIAS_LSB = 1;
  localparam int SLOW_XTAL_EN_BIT = 0;
  localparam int FAST_FILT_BIT = 9;
  localparam int FAST_HOLD_BIT = 8;
  localparam int FAST_CUR_LSB = 5;
  localparam int FAST_RC_TRIM_LSB = 1;
  localparam int FAST_RC_EN_BIT = 0;
  localparam int LP_SEL_BIT = 12;
  localparam int LP_EN_BIT = 11;
  localparam int LP_TUNE_LSB = 4;
  localparam int LP_TRIM_LSB = 0;
  localparam int REF_TEST_BIT = 14;
  localparam int REF_RET_LSB = 10;
  localparam int REF_BIAS_LSB = 5;
  localparam int REF_VOLT_LSB = 0;
  localparam int XTAL_EN_BIT = 0;
  localparam int STAT_SETTLED_BIT = 7;
  localparam int STAT_READY_BIT = 6;

  // step timebase
  localparam int STEP_NS = 250000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int STEP_CYCLES = STEP_NS / CLK_PERIOD_NS;

  // crystal sequencing states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_TRIM = 4'b0010,
    ST_SETTLE = 4'b0100,
    ST_DONE = 4'b1000
  } xtal_state_e;
endpackage

/* rtl/step_timebase.sv */
`timescale 1ns/1ps
module step_timebase import osc_trim_pkg::*; #(
  parameter int STEP_LEN = STEP_CYCLES
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  output logic tick // one-cycle pulse per step
);
  localparam int CW = $clog2(STEP_LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(STEP_LEN - 1);

  logic [CW-1:0] cnt_r;

  // free running, so a wait may start at any phase of the step
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // pulse on the last count of each step
  assign tick = (cnt_r == LAST);
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top import osc_trim_pkg::*; ;
  localparam int STEP_SIM = 8;
  localparam int CYC_LIMIT = 20000;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] addr = 32'h0000_0000;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [9:0] ana_status_in = 10'h090;
  logic [15:0] rdata, applied_trim;
  logic fast_crystal_enable, fast_crystal_settled, fast_crystal_trim_ready;
  logic slow_rc_enable, slow_crystal_enable, slow_crystal_ampreg_off, fast_rc_enable;
  logic fast_crystal_noise_filter, fast_crystal_bias_hold, low_power_osc_select;
  logic low_power_osc_enable, reference_core_off_test;
  logic [3:0] slow_rc_trim, slow_crystal_bias_current, fast_rc_trim, low_power_osc_trim;
  logic [3:0] retention_trim;
  logic [1:0] slow_crystal_bias_resistor;
  logic [2:0] fast_crystal_bias_current;
  logic [6:0] low_power_osc_tune;
  logic [4:0] reference_bias_trim, reference_voltage_trim;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc_cnt = 0;
  integer seed = 1814;
  logic xen = 1'b0;
  logic [15:0] app_exp = 16'h0000;
  // writable registers: address, writable mask, reset value, software shadow
  logic [31:0] rw_addr [6] = '{ADDR_TRIM_TIMING, ADDR_SLOW_OSC, ADDR_FAST_OSC, ADDR_LP_OSC,
                               ADDR_REF_TRIM, ADDR_FREQ_TRIM};
  logic [15:0] msk [6] = '{16'h00FF, 16'h1FFF, 16'h03FF, 16'h1FFF, 16'h7FFF, 16'hFFFF};
  logic [15:0] sh [6] = '{16'h00A2, 16'h07AE, 16'h00A0, 16'h05B0, 16'h0000, 16'h0000};

  osc_trim_ctrl #(.STEP_LEN(STEP_SIM)) i_osc_trim_ctrl (
    .sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .ana_status_in(ana_status_in),
    .fast_crystal_enable(fast_crystal_enable), .applied_trim(applied_trim),
    .fast_crystal_settled(fast_crystal_settled),
    .fast_crystal_trim_ready(fast_crystal_trim_ready), .slow_rc_enable(slow_rc_enable),
    .slow_rc_trim(slow_rc_trim), .slow_crystal_enable(slow_crystal_enable),
    .slow_crystal_ampreg_off(slow_crystal_ampreg_off),
    .slow_crystal_bias_current(slow_crystal_bias_current),
    .slow_crystal_bias_resistor(slow_crystal_bias_resistor), .fast_rc_enable(fast_rc_enable),
    .fast_rc_trim(fast_rc_trim), .fast_crystal_noise_filter(fast_crystal_noise_filter),
    .fast_crystal_bias_hold(fast_crystal_bias_hold),
    .fast_crystal_bias_current(fast_crystal_bias_current),
    .low_power_osc_select(low_power_osc_select), .low_power_osc_enable(low_power_osc_enable),
    .low_power_osc_trim(low_power_osc_trim), .low_power_osc_tune(low_power_osc_tune),
    .reference_core_off_test(reference_core_off_test),
    .reference_bias_trim(reference_bias_trim), .reference_voltage_trim(reference_voltage_trim),
    .retention_trim(retention_trim)
  );

  // clock at 250 MHz
  always #2 sys_clk = ~sys_clk;

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == CYC_LIMIT) begin
      error_cnt = error_cnt + 1;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [31:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // expected system status from the shadow state
  function automatic logic [15:0] stat_exp(input logic settled);
    return {8'h00, settled, app_exp === sh[5], 6'h00};
  endfunction

  // output fields against the shadow registers
  task automatic chk_fields();
    chk("slow_fields", {3'h0, slow_crystal_ampreg_off, slow_rc_trim, slow_rc_enable,
        slow_crystal_bias_current, slow_crystal_bias_resistor, slow_crystal_enable},
        sh[1] & 16'h1FFF);
    chk("fast_fields", {6'h00, fast_crystal_noise_filter, fast_crystal_bias_hold,
        fast_crystal_bias_current, fast_rc_trim, fast_rc_enable}, sh[2]);
    chk("lp_fields", {3'h0, low_power_osc_select, low_power_osc_enable, low_power_osc_tune,
        low_power_osc_trim}, sh[3] & 16'h1FFF);
    chk("ref_fields", {1'b0, reference_core_off_test, retention_trim, reference_bias_trim,
        reference_voltage_trim}, sh[4]);
    chk("xtal_en", {15'h0000, fast_crystal_enable}, {15'h0000, xen});
  endtask

  task automatic chk_regs();
    logic [15:0] d;
    for (int i = 0; i < 6; i++) begin
      rd(rw_addr[i], d);
      chk("reg_readback", d, sh[i]);
    end
    chk_fields();
  endtask

  // full enable, trim, settle and disable sequence with delay bounds
  task automatic run_seq(input logic [3:0] t, input logic [3:0] s);
    int ta;
    int ts;
    logic [15:0] v;
    logic [15:0] d;
    ta = 0;
    ts = 0;
    v = app_exp ^ (16'($random(seed)) | 16'h0001);
    sh[0] = {8'h00, t, s};
    wr(ADDR_TRIM_TIMING, sh[0]);
    sh[5] = v;
    wr(ADDR_FREQ_TRIM, v);
    wait_cyc(2);
    chk("ready_pre", {15'h0000, fast_crystal_trim_ready}, 16'h0000);
    xen = 1'b1;
    wr(ADDR_XTAL_CTRL, 16'h0001);
    while (applied_trim !== v && ta < 300) begin
      @(negedge sys_clk);
      ta++;
    end
    chk("settled_early", {15'h0000, fast_crystal_settled}, 16'h0000);
    while (fast_crystal_settled !== 1'b1 && ts < 300) begin
      @(negedge sys_clk);
      ts++;
    end
    app_exp = v;
    chk("trim_delay", {15'h0000, ta >= (t > 0 ? (t - 1) * STEP_SIM : 0) &&
        ta <= t * STEP_SIM + 4}, 16'h0001);
    chk("settle_delay", {15'h0000, ts >= (s > 0 ? (s - 1) * STEP_SIM : 0) &&
        ts <= s * STEP_SIM + 3}, 16'h0001);
    wait_cyc(1);
    rd(ADDR_SYS_STATUS, d);
    chk("status_done", d, 16'h00C0);
    xen = 1'b0;
    wr(ADDR_XTAL_CTRL, 16'h0000);
    wait_cyc(2);
    chk("settled_off", {15'h0000, fast_crystal_settled}, 16'h0000);
    chk("applied_kept", applied_trim, v);
  endtask

  // main sequence
  initial begin
    logic [15:0] d;
    logic [9:0] a;
    logic [3:0] tt [6] = '{4'h0, 4'h1, 4'h2, 4'h0, 4'hF, 4'hA};
    logic [3:0] ss [6] = '{4'h0, 4'h1, 4'h0, 4'h3, 4'h2, 4'hF};
    @(negedge sys_clk);
    chk("settled_rst", {15'h0000, fast_crystal_settled}, 16'h0000);
    chk("ready_rst", {15'h0000, fast_crystal_trim_ready}, 16'h0001);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    chk_regs();
    rd(ADDR_SYS_STATUS, d);
    chk("status_rst", d, stat_exp(1'b0));
    wait_cyc(6);
    rd(ADDR_ANA_STATUS, d);
    chk("ana_rst", d, 16'h0090);
    // random register traffic, unmapped and read-only places among it
    repeat (4) begin
      for (int i = 0; i < 6; i++) begin
        d = 16'($random(seed));
        // software keeps the reference core-off test bit cleared
        if (i == 4) d[REF_TEST_BIT] = 1'b0;
        wr(rw_addr[i], d);
        sh[i] = d & msk[i];
      end
      wr(ADDR_ANA_STATUS, 16'($random(seed)));
      wr(ADDR_SYS_STATUS, 16'hFFFF);
      wr(32'h5000_0018, 16'($random(seed)));
      chk_regs();
      rd(32'h5000_0018, d);
      chk("unmapped", d, 16'h0000);
      rd(ADDR_SYS_STATUS, d);
      chk("status_ro", d, stat_exp(1'b0));
    end
    // analogue flags, read-only, unused bits dropped
    for (int k = 0; k < 5; k++) begin
      a = (k == 0) ? 10'h3FF : (k == 1) ? 10'h000 : 10'($random(seed));
      @(posedge sys_clk);
      ana_status_in <= a;
      wait_cyc(6);
      rd(ADDR_ANA_STATUS, d);
      chk("ana_status", d, {6'h00, a & 10'h2F7});
    end
    // aborted sequence: disable during the trim wait
    sh[0] = 16'h00F1;
    wr(ADDR_TRIM_TIMING, sh[0]);
    sh[5] = ~app_exp;
    wr(ADDR_FREQ_TRIM, sh[5]);
    xen = 1'b1;
    wr(ADDR_XTAL_CTRL, 16'h0001);
    wait_cyc(20);
    chk("abort_hold", applied_trim, app_exp);
    xen = 1'b0;
    wr(ADDR_XTAL_CTRL, 16'h0000);
    wait_cyc(2);
    chk("abort_settled", {15'h0000, fast_crystal_settled}, 16'h0000);
    chk("abort_ready", {15'h0000, fast_crystal_trim_ready}, 16'h0000);
    // corner and random delay codes
    for (int k = 0; k < 6; k++) begin
      run_seq(tt[k], ss[k]);
    end
    repeat (3) begin
      run_seq(4'($random(seed)), 4'($random(seed)));
    end
    chk_fields();
    close_out();
  end
endmodule
